// file: common/wasc_pkg.sv
// package: constants of the waveform auto-shutdown control
// assumes: one clock domain, byte-addressed Avalon-MM register slave
package wasc_pkg;

    // ****************************************************
    // register byte offsets
    // ****************************************************
    localparam logic [4:0] OFS_STATUS   = 5'h00;
    localparam logic [4:0] OFS_SRC_EN   = 5'h04;
    localparam logic [4:0] OFS_EV_STAT  = 5'h08;
    localparam logic [4:0] OFS_EV_CLR   = 5'h0C;
    localparam logic [4:0] OFS_EV_EN    = 5'h10;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int BIT_SHUTDOWN = 7;
    localparam int BIT_RESTART  = 6;
    localparam int POS_BD_STATE = 4;
    localparam int POS_AC_STATE = 2;
    localparam int NUM_SRC      = 5;
    localparam int NUM_EV       = 2;
    localparam int EV_ENTERED   = 0;
    localparam int EV_RELEASED  = 1;

    // ****************************************************
    // reset values and fixed read bits
    // ****************************************************
    localparam logic [1:0] RST_BD_STATE = 2'h1;
    localparam logic [1:0] RST_AC_STATE = 2'h1;
    localparam logic [2:0] SRC_EN_TOP   = 3'h7;

    // ****************************************************
    // pair override encodings
    // ****************************************************
    localparam logic [1:0] ST_INACTIVE = 2'h0;
    localparam logic [1:0] ST_TRISTATE = 2'h1;
    localparam logic [1:0] ST_LOW      = 2'h2;
    localparam logic [1:0] ST_HIGH     = 2'h3;

    typedef enum logic {
        WASC_RUN  = 1'b0,
        WASC_HOLD = 1'b1
    } wasc_mode_t;

endpackage

// file: verilog/wasc_rise_det.sv
// rising edge detector for the waveform input
// assumes: input synchronous to mclk
module wasc_rise_det (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic sig,
    output logic      rise
);
    typedef struct packed {
        logic prev;
    } wasc_rise_st_t;

    wasc_rise_st_t s_r;
    wasc_rise_st_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.prev = sig;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rise = sig & ~s_r.prev;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_rise_one_cycle: assert property (rise |=> !rise) else $error("rise lasted two cycles");
endmodule

// file: verilog/wasc_pair_out.sv
// output override for one pair of generator outputs
// assumes: wave and db_done come from the dead-band logic
module wasc_pair_out (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       active,
    input  wire logic [1:0] state,
    input  wire logic [1:0] wave,
    input  wire logic [1:0] pol,
    input  wire logic       db_done,
    output logic      [1:0] pin_out,
    output logic      [1:0] pin_oe
);
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } wasc_pair_st_t;

    wasc_pair_st_t s_r;
    wasc_pair_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!active) begin
            s_nxt.out = wave;
            s_nxt.oe  = 2'h3;
        end else begin
            case (state)
                wasc_pkg::ST_HIGH: begin
                    s_nxt.out = 2'h3;
                    s_nxt.oe  = 2'h3;
                end
                wasc_pkg::ST_LOW: begin
                    s_nxt.out = 2'h0;
                    s_nxt.oe  = 2'h3;
                end
                wasc_pkg::ST_TRISTATE: begin
                    s_nxt.out = 2'h0;
                    s_nxt.oe  = 2'h0;
                end
                default: begin
                    s_nxt.oe = 2'h3;
                    if (db_done) begin
                        s_nxt.out = pol;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_out = s_r.out;
    assign pin_oe  = s_r.oe;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_force_high: assert property (active && state == wasc_pkg::ST_HIGH |=> pin_out == 2'h3 && pin_oe == 2'h3)
        else $error("pair not forced high");
    chk_force_low: assert property (active && state == wasc_pkg::ST_LOW |=> pin_out == 2'h0 && pin_oe == 2'h3)
        else $error("pair not forced low");
    chk_pair_tristate: assert property (active && state == wasc_pkg::ST_TRISTATE |=> pin_oe == 2'h0)
        else $error("pair not released to high impedance");
    chk_inactive_level: assert property (active && state == wasc_pkg::ST_INACTIVE && db_done |=> pin_out == $past(pol))
        else $error("inactive level wrong");
    chk_inactive_wait: assert property (active && state == wasc_pkg::ST_INACTIVE && !db_done |=> $stable(pin_out))
        else $error("inactive level before dead-band");
endmodule

// file: verilog/wasc_top.sv
// auto-shutdown control of a complementary waveform generator
// assumes: all inputs synchronous to mclk, Avalon-MM master with waitrequest
// Behaviour
// - status bit shows shutdown in effect
// - pair B/D forced high, low or tristate
// - pair A/C forced high, low or tristate
// - state 00 drives polarity level after dead-band
// - software may set shutdown while generator off
// - outputs held until next waveform rising edge
// - logic cell two source gated by enable
// - second comparator source gated by enable
// - first comparator source gated by enable
// - timer postscale source gated by enable
// - selected input pin source gated by enable
//
// Added by the designer: the register offsets and the Avalon-MM register port.
module wasc_top #(
    parameter int ADDR_W = 5
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              generator_enable,
    input  wire logic              waveform_in,
    input  wire logic              logic_cell_two_output,
    input  wire logic              second_comparator_output,
    input  wire logic              first_comparator_output,
    input  wire logic              second_timer_postscaled,
    input  wire logic              shutdown_pin_selector,
    input  wire logic [1:0]        wave_ac,
    input  wire logic [1:0]        wave_bd,
    input  wire logic [1:0]        polarity_ac,
    input  wire logic [1:0]        polarity_bd,
    input  wire logic              deadband_done,
    output logic      [1:0]        outputs_a_and_c,
    output logic      [1:0]        outputs_a_and_c_oe,
    output logic      [1:0]        outputs_b_and_d,
    output logic      [1:0]        outputs_b_and_d_oe,
    output logic                   shutdown_active,
    output logic                   irq
);
    // ****************************************************
    // elaboration checks
    // ****************************************************
    if (ADDR_W < 5) begin : g_bad_addr
        $error("ADDR_W must be at least 5");
    end

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic                          ack;
        logic [31:0]                   rdata;
        logic                          shut;
        logic                          restart;
        logic [1:0]                    bd_state;
        logic [1:0]                    ac_state;
        logic [wasc_pkg::NUM_SRC-1:0]  src_en;
        wasc_pkg::wasc_mode_t          mode;
        logic [wasc_pkg::NUM_EV-1:0]   ev_st;
        logic [wasc_pkg::NUM_EV-1:0]   ev_en;
    } wasc_top_st_t;

    wasc_top_st_t s_r;
    wasc_top_st_t s_nxt;

    logic                         req;
    logic                         commit;
    logic                         lane0;
    logic                         hi_addr;
    logic [4:0]                   ofs;
    logic                         wr_status;
    logic                         wr_src_en;
    logic                         wr_ev_clr;
    logic                         wr_ev_en;
    logic                         sw_set;
    logic                         sw_clear;
    logic [wasc_pkg::NUM_SRC-1:0] sources;
    logic                         src_active;
    logic                         auto_clear;
    logic                         rise;
    logic [wasc_pkg::NUM_EV-1:0]  ev_hit;
    logic [7:0]                   status_byte;

    // ****************************************************
    // bus decode
    // ****************************************************
    assign req     = avs_read | avs_write;
    assign commit  = req & s_r.ack;
    assign lane0   = avs_byteenable[0];
    assign ofs     = avs_address[4:0];
    if (ADDR_W > 5) begin : g_hi
        assign hi_addr = |avs_address[ADDR_W-1:5];
    end else begin : g_no_hi
        assign hi_addr = 1'b0;
    end

    assign wr_status = commit & avs_write & lane0 & !hi_addr & (ofs == wasc_pkg::OFS_STATUS);
    assign wr_src_en = commit & avs_write & lane0 & !hi_addr & (ofs == wasc_pkg::OFS_SRC_EN);
    assign wr_ev_clr = commit & avs_write & lane0 & !hi_addr & (ofs == wasc_pkg::OFS_EV_CLR);
    assign wr_ev_en  = commit & avs_write & lane0 & !hi_addr & (ofs == wasc_pkg::OFS_EV_EN);

    // ****************************************************
    // shutdown sources
    // ****************************************************
    assign sources = {logic_cell_two_output, second_comparator_output, first_comparator_output,
                      second_timer_postscaled, shutdown_pin_selector};
    assign src_active = |(sources & s_r.src_en);

    // software set only while generator off
    assign sw_set     = wr_status & avs_writedata[wasc_pkg::BIT_SHUTDOWN] & !generator_enable;
    assign sw_clear   = wr_status & !avs_writedata[wasc_pkg::BIT_SHUTDOWN];
    assign auto_clear = s_r.restart & !src_active;

    wasc_rise_det u_rise (
        .mclk (mclk),
        .srst (srst),
        .sig  (waveform_in),
        .rise (rise)
    );

    assign status_byte = {s_r.shut, s_r.restart, s_r.bd_state, s_r.ac_state, 2'h0};

    always_comb begin
        s_nxt = s_r;

        // one wait state per access
        s_nxt.ack = req & !s_r.ack;
        if (req && !s_r.ack) begin
            s_nxt.rdata = 32'h0000_0000;
            if (!hi_addr) begin
                case (ofs)
                    wasc_pkg::OFS_STATUS:  s_nxt.rdata = {24'h00_0000, status_byte};
                    wasc_pkg::OFS_SRC_EN:  s_nxt.rdata = {24'h00_0000, wasc_pkg::SRC_EN_TOP, s_r.src_en};
                    wasc_pkg::OFS_EV_STAT: s_nxt.rdata = {30'h0000_0000, s_r.ev_st};
                    wasc_pkg::OFS_EV_EN:   s_nxt.rdata = {30'h0000_0000, s_r.ev_en};
                    default:               s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end

        if (wr_status) begin
            s_nxt.restart  = avs_writedata[wasc_pkg::BIT_RESTART];
            s_nxt.bd_state = avs_writedata[wasc_pkg::POS_BD_STATE +: 2];
            s_nxt.ac_state = avs_writedata[wasc_pkg::POS_AC_STATE +: 2];
        end
        if (wr_src_en) begin
            s_nxt.src_en = avs_writedata[wasc_pkg::NUM_SRC-1:0];
        end
        if (wr_ev_en) begin
            s_nxt.ev_en = avs_writedata[wasc_pkg::NUM_EV-1:0];
        end

        // hardware set wins over any clear
        s_nxt.shut = src_active | sw_set | (s_r.shut & !sw_clear & !auto_clear);

        // hold until rising edge after clear
        case (s_r.mode)
            wasc_pkg::WASC_RUN: begin
                if (s_r.shut) begin
                    s_nxt.mode = wasc_pkg::WASC_HOLD;
                end
            end
            wasc_pkg::WASC_HOLD: begin
                if (!s_r.shut && rise) begin
                    s_nxt.mode = wasc_pkg::WASC_RUN;
                end
            end
            default: s_nxt.mode = wasc_pkg::WASC_RUN;
        endcase

        // event flags, set wins over clear
        if (wr_ev_clr) begin
            s_nxt.ev_st = s_r.ev_st & ~avs_writedata[wasc_pkg::NUM_EV-1:0];
        end
        s_nxt.ev_st = s_nxt.ev_st | ev_hit;
    end

    // entry taken from the set terms, not s_nxt, to keep the comb path acyclic
    assign ev_hit[wasc_pkg::EV_ENTERED]  = (src_active | sw_set) & !s_r.shut;
    assign ev_hit[wasc_pkg::EV_RELEASED] = (s_r.mode == wasc_pkg::WASC_HOLD) & !s_r.shut & rise;

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_r          <= '0;
            s_r.bd_state <= wasc_pkg::RST_BD_STATE;
            s_r.ac_state <= wasc_pkg::RST_AC_STATE;
            s_r.mode     <= wasc_pkg::WASC_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign avs_waitrequest = req & !s_r.ack;
    assign avs_readdata    = s_r.rdata;
    assign shutdown_active = (s_r.mode == wasc_pkg::WASC_HOLD);
    assign irq             = |(s_r.ev_st & s_r.ev_en);

    wasc_pair_out u_pair_ac (
        .mclk    (mclk),
        .srst    (srst),
        .active  (shutdown_active),
        .state   (s_r.ac_state),
        .wave    (wave_ac),
        .pol     (polarity_ac),
        .db_done (deadband_done),
        .pin_out (outputs_a_and_c),
        .pin_oe  (outputs_a_and_c_oe)
    );

    wasc_pair_out u_pair_bd (
        .mclk    (mclk),
        .srst    (srst),
        .active  (shutdown_active),
        .state   (s_r.bd_state),
        .wave    (wave_bd),
        .pol     (polarity_bd),
        .db_done (deadband_done),
        .pin_out (outputs_b_and_d),
        .pin_oe  (outputs_b_and_d_oe)
    );

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_source_sets_shut: assert property (src_active |=> s_r.shut ##1 shutdown_active)
        else $error("enabled source did not enter shutdown");
    chk_masked_src: assert property (!src_active && !s_r.shut && !sw_set |=> !s_r.shut)
        else $error("disabled source caused shutdown");
    chk_status_bit: assert property (s_r.ack && avs_read && ofs == wasc_pkg::OFS_STATUS && !hi_addr
                                     |-> avs_readdata[wasc_pkg::BIT_SHUTDOWN] == $past(s_r.shut))
        else $error("status bit read wrong");
    chk_sw_set_off: assert property (sw_set |=> s_r.shut ##1 shutdown_active)
        else $error("software set did not shut down");
    chk_sw_set_on: assert property (wr_status && generator_enable && !src_active && !s_r.shut |=> !s_r.shut)
        else $error("software set accepted while generator on");
    chk_hold_wait: assert property (shutdown_active && !s_r.shut && !rise |=> shutdown_active)
        else $error("released before waveform edge");
    chk_hold_release: assert property (shutdown_active && !s_r.shut && rise |=> !shutdown_active)
        else $error("not released on waveform edge");
    chk_auto_restart: assert property (s_r.shut && s_r.restart && !src_active && !sw_set |=> !s_r.shut)
        else $error("auto-restart did not clear");
    chk_no_restart: assert property (s_r.shut && !s_r.restart && !wr_status |=> s_r.shut)
        else $error("status cleared without software");
    chk_bus_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");
endmodule

// file: sim/tb_top.sv
// self-checking bench of the waveform auto-shutdown control
// assumes: wasc_pkg and the design files are compiled first
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************
    // stimulus and observed signals
    // ****************************************************
    logic        mclk             = 1'b0;
    logic        srst             = 1'b1;
    logic [4:0]  avs_address      = 5'h00;
    logic        avs_read         = 1'b0;
    logic        avs_write        = 1'b0;
    logic [31:0] avs_writedata    = 32'h0;
    logic [3:0]  avs_byteenable   = 4'hF;
    logic        generator_enable = 1'b0;
    logic        waveform_in      = 1'b0;
    logic [4:0]  src              = 5'h00;
    logic [1:0]  wave_ac          = 2'h1;
    logic [1:0]  wave_bd          = 2'h2;
    logic [1:0]  polarity_ac      = 2'h2;
    logic [1:0]  polarity_bd      = 2'h1;
    logic        deadband_done    = 1'b1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  out_ac;
    logic [1:0]  oe_ac;
    logic [1:0]  out_bd;
    logic [1:0]  oe_bd;
    logic        shutdown_active;
    logic        irq;
    int          err_count        = 0;
    int          tests_run        = 0;

    always #25 mclk = ~mclk;

    wasc_top i_wasc_top (
        .mclk                     (mclk),
        .srst                     (srst),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_byteenable           (avs_byteenable),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .generator_enable         (generator_enable),
        .waveform_in              (waveform_in),
        .logic_cell_two_output    (src[4]),
        .second_comparator_output (src[3]),
        .first_comparator_output  (src[2]),
        .second_timer_postscaled  (src[1]),
        .shutdown_pin_selector    (src[0]),
        .wave_ac                  (wave_ac),
        .wave_bd                  (wave_bd),
        .polarity_ac              (polarity_ac),
        .polarity_bd              (polarity_bd),
        .deadband_done            (deadband_done),
        .outputs_a_and_c          (out_ac),
        .outputs_a_and_c_oe       (oe_ac),
        .outputs_b_and_d          (out_bd),
        .outputs_b_and_d_oe       (oe_bd),
        .shutdown_active          (shutdown_active),
        .irq                      (irq)
    );

    // ****************************************************
    // bus and helper tasks
    // ****************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        `CHK("waitrequest", 1'b0, avs_waitrequest)
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] ex);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(nm, ex, q)
    endtask

    // clears the status bit, then releases on a waveform rising edge
    task automatic release_out(input logic [7:0] v);
        wr(wasc_pkg::OFS_STATUS, v);
        tick(3);
        `CHK("held before edge", 1'b1, shutdown_active)
        waveform_in <= 1'b1;
        tick(3);
        `CHK("released after edge", 1'b0, shutdown_active)
        waveform_in <= 1'b0;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        tick(5000);
        err_count++;
        test_done();
    end

    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        logic [1:0] st;
        tick(3);
        srst <= 1'b0;
        tick(3);
        `CHK("pins normal", wave_ac, out_ac)
        rc("status reset", wasc_pkg::OFS_STATUS, 32'h14);
        rc("src_en reset", wasc_pkg::OFS_SRC_EN, 32'hE0);
        rc("ev_stat reset", wasc_pkg::OFS_EV_STAT, 32'h00);
        rc("ev_en reset", wasc_pkg::OFS_EV_EN, 32'h00);
        wr(5'h14, 8'hFF);
        rc("unmapped", 5'h14, 32'h00);
        rc("unmapped keeps status", wasc_pkg::OFS_STATUS, 32'h14);
        rc("unmapped keeps src_en", wasc_pkg::OFS_SRC_EN, 32'hE0);
        avs_byteenable <= 4'h0;
        wr(wasc_pkg::OFS_SRC_EN, 8'h1F);
        avs_byteenable <= 4'hF;
        rc("byteenable off", wasc_pkg::OFS_SRC_EN, 32'hE0);
        $display("test registers done");

        for (int i = 0; i < wasc_pkg::NUM_SRC; i++) begin
            src <= 5'h01 << i;
            tick(4);
            `CHK("disabled source", 1'b0, shutdown_active)
            src <= 5'h00;
            wr(wasc_pkg::OFS_SRC_EN, 8'h01 << i);
            src <= 5'h01 << i;
            tick(4);
            `CHK("enabled source", 1'b1, shutdown_active)
            rc("status set", wasc_pkg::OFS_STATUS, 32'h94);
            src <= 5'h00;
            release_out(8'h14);
            rc("status clear", wasc_pkg::OFS_STATUS, 32'h14);
            wr(wasc_pkg::OFS_SRC_EN, 8'h00);
        end
        $display("test sources done");

        for (int s = 3; s > 0; s--) begin
            st = s[1:0];
            wr(wasc_pkg::OFS_STATUS, {2'b10, st, st, 2'b00});
            tick(4);
            `CHK("oe ac", (st == wasc_pkg::ST_TRISTATE) ? 2'h0 : 2'h3, oe_ac)
            `CHK("oe bd", (st == wasc_pkg::ST_TRISTATE) ? 2'h0 : 2'h3, oe_bd)
            if (st != wasc_pkg::ST_TRISTATE) begin
                `CHK("out ac", (st == wasc_pkg::ST_HIGH) ? 2'h3 : 2'h0, out_ac)
                `CHK("out bd", (st == wasc_pkg::ST_HIGH) ? 2'h3 : 2'h0, out_bd)
            end
            release_out(8'h14);
        end
        deadband_done <= 1'b0;
        wr(wasc_pkg::OFS_STATUS, 8'h80);
        tick(4);
        `CHK("ac before deadband", wave_ac, out_ac)
        `CHK("bd before deadband", wave_bd, out_bd)
        deadband_done <= 1'b1;
        tick(3);
        `CHK("ac inactive", polarity_ac, out_ac)
        `CHK("bd inactive", polarity_bd, out_bd)
        `CHK("oe inactive", 2'h3, oe_ac)
        release_out(8'h14);
        $display("test override done");

        generator_enable <= 1'b1;
        wr(wasc_pkg::OFS_STATUS, 8'h94);
        tick(4);
        `CHK("set while enabled", 1'b0, shutdown_active)
        rc("status refused", wasc_pkg::OFS_STATUS, 32'h14);
        generator_enable <= 1'b0;
        $display("test software set done");

        wr(wasc_pkg::OFS_EV_CLR, 8'h03);
        rc("ev_stat cleared", wasc_pkg::OFS_EV_STAT, 32'h00);
        wr(wasc_pkg::OFS_EV_EN, 8'h01);
        wr(wasc_pkg::OFS_STATUS, 8'h54);
        wr(wasc_pkg::OFS_SRC_EN, 8'h04);
        src <= 5'h04;
        tick(4);
        `CHK("irq raised", 1'b1, irq)
        rc("restart source on", wasc_pkg::OFS_STATUS, 32'hD4);
        src <= 5'h00;
        tick(3);
        rc("restart cleared", wasc_pkg::OFS_STATUS, 32'h54);
        `CHK("restart still held", 1'b1, shutdown_active)
        wr(wasc_pkg::OFS_EV_EN, 8'h00);
        tick(2);
        `CHK("irq masked", 1'b0, irq)
        wr(wasc_pkg::OFS_EV_EN, 8'h01);
        tick(2);
        `CHK("irq unmasked", 1'b1, irq)
        wr(wasc_pkg::OFS_EV_CLR, 8'h01);
        tick(2);
        `CHK("irq cleared", 1'b0, irq)
        rc("ev_clr reads", wasc_pkg::OFS_EV_CLR, 32'h00);
        release_out(8'h14);
        rc("release event", wasc_pkg::OFS_EV_STAT, 32'h02);
        $display("test restart done");
        test_done();
    end
endmodule
